// ---- core/ccp_capture_compare_unit.sv ----
// Purpose: eight capture/compare channels behind an Avalon-MM slave
// Assumes: timers and pins synchronous to CLK_I
// Notes  : waitrequest drops one cycle after a request is seen
`timescale 1ns/1ps
`default_nettype none
module ccp_capture_compare_unit
  import ccp_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // timer pairs 1, 3, 5, 7
  input  wire logic [15:0] TMR1_I,
  input  wire logic [15:0] TMR3_I,
  input  wire logic [15:0] TMR5_I,
  input  wire logic [15:0] TMR7_I,
  output logic      [3:0]  TMR_RESET_O,
  // channel pins
  input  wire logic [7:0]  PIN_I,
  input  wire logic [3:0]  ALT_PIN_I,
  input  wire logic [7:0]  PORT_WR_I,
  input  wire logic [7:0]  PIN_DIR_OUT_I,
  output logic      [7:0]  PIN_O,
  output logic      [7:0]  PIN_DRIVE_O,
  output logic      [3:0]  ALT_PIN_O,
  output logic      [3:0]  ALT_DRIVE_O,
  // interrupt requests
  output logic      [7:0]  IRQ_REQ_O,
  output logic             IRQ_HIGH_O,
  output logic             IRQ_LOW_O
);
  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  prios;
    logic [7:0]  tsel_one;
    logic [7:0]  tsel_two;
    logic [7:0]  config_r;
    logic        wait_req;
    logic [31:0] rdata;
    logic [3:0]  tmr_rst;
    logic [7:0]  pin_o;
    logic [7:0]  pin_drv;
    logic [3:0]  alt_o;
    logic [3:0]  alt_drv;
    logic [7:0]  irq;
    logic        irq_hi;
    logic        irq_lo;
  } top_state_t;

  top_state_t  st_reg;
  top_state_t  st_next;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [7:0]  aw;
  logic        ch_hit;
  logic [2:0]  ch_idx;
  logic [1:0]  sub;
  logic        wr_fire;
  logic        rd_take;
  logic        ch_wr;
  logic [7:0]  wd8;
  logic [7:0]  rd8;
  logic [15:0] tsel_all;

  assign aw       = {AVS_ADDRESS_I[7:2], 2'b00};
  assign ch_hit   = (aw >= OFS_CH_BASE) && (aw < OFS_CH_END);
  assign ch_idx   = 3'(aw[7:4] - CH_BASE_IDX);
  assign sub      = aw[3:2];
  assign wr_fire  = AVS_WRITE_I && !st_reg.wait_req && AVS_BYTEENABLE_I[0];
  assign rd_take  = AVS_READ_I && st_reg.wait_req;
  assign ch_wr    = wr_fire && ch_hit;
  assign wd8      = AVS_WRITEDATA_I[7:0];
  assign tsel_all = {st_reg.tsel_two, st_reg.tsel_one};

  // ----------------------------------------------------------------
  // per-channel wiring
  // ----------------------------------------------------------------
  logic [15:0] tmr_arr [4];
  logic [3:0]  mode_a  [NCH];
  logic [15:0] value_a [NCH];
  logic [1:0]  tsel_a  [NCH];
  logic [7:0]  hit_v;
  logic [7:0]  trig_v;
  logic [7:0]  pin_o_v;
  logic [7:0]  pin_drv_v;
  logic [3:0]  alt_o_v;
  logic [3:0]  alt_drv_v;

  assign tmr_arr[0] = TMR1_I;
  assign tmr_arr[1] = TMR3_I;
  assign tmr_arr[2] = TMR5_I;
  assign tmr_arr[3] = TMR7_I;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      ccp_chan_if chi ();
      logic       owns;
      logic       pin_sel;

      assign tsel_a[g]   = tsel_all[2*g +: 2];
      assign chi.timer   = tmr_arr[tsel_a[g]];
      assign chi.wdata   = wd8;
      assign chi.wr_ctrl = ch_wr && (ch_idx == 3'(g)) && (sub == SUB_CTRL);
      assign chi.wr_low  = ch_wr && (ch_idx == 3'(g)) && (sub == SUB_LOW);
      assign chi.wr_high = ch_wr && (ch_idx == 3'(g)) && (sub == SUB_HIGH);
      assign chi.port_wr = PORT_WR_I[g];
      assign chi.dir_out = PIN_DIR_OUT_I[g];
      assign mode_a[g]   = chi.mode;
      assign value_a[g]  = chi.value;
      assign hit_v[g]    = chi.event_hit;
      assign trig_v[g]   = chi.special_trig;
      // software interrupt and trigger modes leave the port latch on the pin
      assign owns = (chi.mode == MODE_CMP_TOG) || (chi.mode == MODE_CMP_HIGH)
                    || (chi.mode == MODE_CMP_LOW);

      if (g >= 3 && g <= 6) begin : g_mux
        assign pin_sel          = st_reg.config_r[PGS_BIT];
        assign chi.pin_in       = pin_sel ? PIN_I[g] : ALT_PIN_I[g-3];
        assign pin_o_v[g]       = pin_sel && chi.out_latch;
        assign pin_drv_v[g]     = pin_sel && owns;
        assign alt_o_v[g-3]     = !pin_sel && chi.out_latch;
        assign alt_drv_v[g-3]   = !pin_sel && owns;
      end else begin : g_fix
        assign pin_sel          = 1'b1;
        assign chi.pin_in       = PIN_I[g];
        assign pin_o_v[g]       = chi.out_latch;
        assign pin_drv_v[g]     = owns;
      end

      ccp_channel_unit u_unit (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .ch      (chi)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register file and outputs
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    rd8              = 8'h00;
    // bus handshake: one wait cycle per request
    st_next.wait_req = !((AVS_READ_I || AVS_WRITE_I) && st_reg.wait_req);
    // read mux, unmapped reads return zero
    if (ch_hit) begin
      case (sub)
        SUB_CTRL: rd8 = {4'h0, mode_a[ch_idx]};
        SUB_LOW:  rd8 = value_a[ch_idx][7:0];
        SUB_HIGH: rd8 = value_a[ch_idx][15:8];
        default:  rd8 = 8'h00;
      endcase
    end else begin
      case (aw)
        OFS_FLAGS:    rd8 = st_reg.flags;
        OFS_ENABLES:  rd8 = st_reg.enables;
        OFS_PRIOS:    rd8 = st_reg.prios;
        OFS_TSEL_ONE: rd8 = st_reg.tsel_one;
        OFS_TSEL_TWO: rd8 = st_reg.tsel_two;
        OFS_CONFIG:   rd8 = st_reg.config_r;
        default:      rd8 = 8'h00;
      endcase
    end
    if (rd_take) st_next.rdata = {24'h000000, rd8};
    if (wr_fire && aw == OFS_ENABLES) st_next.enables = wd8;
    if (wr_fire && aw == OFS_PRIOS) st_next.prios = wd8;
    if (wr_fire && aw == OFS_TSEL_ONE) st_next.tsel_one = wd8;
    if (wr_fire && aw == OFS_TSEL_TWO) st_next.tsel_two = wd8;
    if (wr_fire && aw == OFS_CONFIG) st_next.config_r = wd8;
    // sticky flags, set wins over clear
    if (wr_fire && aw == OFS_FLAGS) st_next.flags = wd8;
    st_next.flags = st_next.flags | hit_v;
    // trigger only resets the assigned timer
    st_next.tmr_rst = 4'h0;
    for (int i = 0; i < NCH; i++) begin
      if (trig_v[i]) st_next.tmr_rst[tsel_a[i]] = 1'b1;
    end
    st_next.pin_o   = pin_o_v;
    st_next.pin_drv = pin_drv_v;
    st_next.alt_o   = alt_o_v;
    st_next.alt_drv = alt_drv_v;
    // request reaches the processor only when enabled
    st_next.irq     = st_reg.flags & st_reg.enables;
    st_next.irq_hi  = |(st_reg.flags & st_reg.enables & st_reg.prios);
    st_next.irq_lo  = |(st_reg.flags & st_reg.enables & ~st_reg.prios);
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      st_reg          <= '0;
      st_reg.config_r <= RST_CONFIG;
      st_reg.wait_req <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign AVS_READDATA_O    = st_reg.rdata;
  assign AVS_WAITREQUEST_O = st_reg.wait_req;
  assign TMR_RESET_O       = st_reg.tmr_rst;
  assign PIN_O             = st_reg.pin_o;
  assign PIN_DRIVE_O       = st_reg.pin_drv;
  assign ALT_PIN_O         = st_reg.alt_o;
  assign ALT_DRIVE_O       = st_reg.alt_drv;
  assign IRQ_REQ_O         = st_reg.irq;
  assign IRQ_HIGH_O        = st_reg.irq_hi;
  assign IRQ_LOW_O         = st_reg.irq_lo;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_alt_sel;
    !st_reg.config_r[PGS_BIT] [*2];
  endsequence

  AST_BUS_ANSWER: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
                                   |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest did not drop");
  AST_FLAG_SET: assert property (hit_v != 8'h00
                                 |=> (st_reg.flags & $past(hit_v)) == $past(hit_v))
    else $error("event flag not set");
  AST_FLAG_STICKY: assert property (!(wr_fire && aw == OFS_FLAGS)
                                    |=> (st_reg.flags & $past(st_reg.flags))
                                        == $past(st_reg.flags))
    else $error("flag cleared by hardware");
  AST_PIN_GROUP: assert property (s_alt_sel |-> PIN_O[6:3] == 4'h0
                                  && PIN_DRIVE_O[6:3] == 4'h0)
    else $error("primary pins driven in alternate group");
  AST_TIMER_RESET: assert property (trig_v[1] |=> TMR_RESET_O[$past(tsel_a[1])])
    else $error("assigned timer not reset");
  AST_IRQ_GATE: assert property (##1 IRQ_REQ_O == $past(st_reg.flags & st_reg.enables))
    else $error("interrupt request not gated by enable");
endmodule
`default_nettype wire

// ---- core/ccp_channel_unit.sv ----
// Purpose: one capture/compare channel
// Assumes: pin and timer inputs synchronous to clk_i
// Notes  : hit and trig are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module ccp_channel_unit
  import ccp_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // channel link
  ccp_chan_if.unit  ch
);
  typedef struct packed {
    logic [3:0]  mode;
    logic [15:0] value;
    logic [3:0]  presc;
    logic        pin_prev;
    logic        eq_prev;
    logic        out_latch;
    logic        hit;
    logic        trig;
  } chan_state_t;

  chan_state_t st_reg;
  chan_state_t st_next;
  logic        is_cap;
  logic        is_cmp;
  logic        rise;
  logic        fall;
  logic        cap_ev;
  logic        match;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    is_cap           = (st_reg.mode[3:2] == 2'b01);
    is_cmp           = (st_reg.mode[3:2] == 2'b10) || (st_reg.mode == MODE_CMP_TOG);
    rise             = ch.pin_in && !st_reg.pin_prev;
    fall             = !ch.pin_in && st_reg.pin_prev;
    st_next.pin_prev = ch.pin_in;
    st_next.hit      = 1'b0;
    st_next.trig     = 1'b0;
    case (st_reg.mode)
      MODE_CAP_FALL: cap_ev = fall;
      MODE_CAP_RISE: cap_ev = rise;
      MODE_CAP_4TH:  cap_ev = rise && ((st_reg.presc & PRESC_MASK_4) == PRESC_MASK_4);
      MODE_CAP_16TH: cap_ev = rise && (st_reg.presc == PRESC_MASK_16);
      default:       cap_ev = 1'b0;
    endcase
    if (is_cap && ch.dir_out && ch.port_wr) cap_ev = 1'b1;
    if (!is_cap) st_next.presc = 4'h0;
    else if (rise) st_next.presc = st_reg.presc + 4'h1;
    st_next.eq_prev = is_cmp && (ch.timer == st_reg.value);
    match           = st_next.eq_prev && !st_reg.eq_prev;
    if (ch.wr_low) st_next.value[7:0] = ch.wdata;
    if (ch.wr_high) st_next.value[15:8] = ch.wdata;
    if (cap_ev) begin
      st_next.value = ch.timer;
      st_next.hit   = 1'b1;
    end
    if (match) begin
      st_next.hit = 1'b1;
      case (st_reg.mode)
        MODE_CMP_TOG:  st_next.out_latch = !st_reg.out_latch;
        MODE_CMP_HIGH: st_next.out_latch = 1'b1;
        MODE_CMP_LOW:  st_next.out_latch = 1'b0;
        MODE_CMP_SPEC: st_next.trig = 1'b1;
        default:       st_next.out_latch = st_reg.out_latch;
      endcase
    end
    if (ch.wr_ctrl) begin
      st_next.mode = ch.wdata[3:0];
      if (ch.wdata == 8'h00) st_next.out_latch = 1'b0;
      if (ch.wdata[3:0] == MODE_OFF) st_next.presc = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign ch.mode         = st_reg.mode;
  assign ch.value        = st_reg.value;
  assign ch.event_hit    = st_reg.hit;
  assign ch.special_trig = st_reg.trig;
  assign ch.out_latch    = st_reg.out_latch;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_off_hold;
    (st_reg.mode == MODE_OFF) [*2];
  endsequence
  sequence s_tog_match;
    (st_reg.mode == MODE_CMP_TOG) && match && !ch.wr_ctrl;
  endsequence

  AST_PRESC_CLEARED: assert property (s_off_hold |-> st_reg.presc == 4'h0)
    else $error("prescaler not cleared while off");
  AST_CAPTURE_VALUE: assert property (cap_ev |=> ch.event_hit && ch.value == $past(ch.timer))
    else $error("capture did not store timer");
  AST_TOGGLE: assert property (s_tog_match |=> ch.out_latch != $past(ch.out_latch))
    else $error("toggle match did not toggle");
  AST_SWINT_PIN: assert property (st_reg.mode == MODE_CMP_SWINT && match && !ch.wr_ctrl
                                  |=> $stable(ch.out_latch) && ch.event_hit)
    else $error("software interrupt mode moved pin");
  AST_SPECIAL: assert property (st_reg.mode == MODE_CMP_SPEC && match
                                |=> ch.special_trig && ch.event_hit)
    else $error("special trigger missing");
  AST_ZERO_WRITE: assert property (ch.wr_ctrl && ch.wdata == 8'h00 |=> !ch.out_latch)
    else $error("latch not forced low");
endmodule
`default_nettype wire

// ---- dv/ccp_pin_model.sv ----
// Purpose: far-side pins of the capture/compare unit
// Assumes: levels change just after a rising edge
// Notes  : each level is held at least one cycle
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_model (
  // clock
  input  wire logic       clk_i,
  // levels toward the unit
  output logic      [7:0] pin_o,
  output logic      [3:0] alt_o,
  output logic      [7:0] dir_out_o,
  output logic      [7:0] port_wr_o
);
  initial begin
    pin_o     = 8'h00;
    alt_o     = 4'h0;
    dir_out_o = 8'h00;
    port_wr_o = 8'h00;
  end
  task automatic set_dir(input int i, input logic v);
    @(posedge clk_i);
    dir_out_o[i] <= v;
  endtask
  task automatic drive(input int i, input logic alt, input logic v);
    @(posedge clk_i);
    if (alt) begin
      alt_o[i] <= v;
    end else begin
      pin_o[i] <= v;
    end
    @(posedge clk_i);
  endtask
  task automatic port_write(input int i);
    @(posedge clk_i);
    port_wr_o[i] <= 1'b1;
    @(posedge clk_i);
    port_wr_o[i] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: register-level tests of the capture/compare unit
// Assumes: timers are counters or constants driven here
// Notes  : pins come from the pin model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top
  import ccp_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b, rd, wr, waitreq, irq_hi, irq_lo, tmr_clr;
  logic [7:0]  addr, pin_o, drive_o, irq, pin_i, dir, pwr;
  logic [3:0]  be, tmr_rst, alt_i, alt_q, alt_drv;
  logic [31:0] wdat, rdat;
  logic [15:0] tmr1 = 16'h0000;
  logic [15:0] tmr3;
  int          fails = 0;
  int          checks_done = 0;
  logic [3:0]  cm [4] = '{MODE_CMP_HIGH, MODE_CMP_LOW, MODE_CMP_TOG, MODE_CMP_SWINT};
  logic [1:0]  cx [4] = '{2'b11, 2'b01, 2'b11, 2'b00};
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    tmr1 <= (!rst_b || tmr_rst[0] || tmr_clr) ? 16'h0000 : tmr1 + 16'h0001;
  end
  ccp_pin_model pm (.clk_i(clk), .pin_o(pin_i), .alt_o(alt_i), .dir_out_o(dir),
                    .port_wr_o(pwr));
  ccp_capture_compare_unit dut (.CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdat),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitreq), .TMR1_I(tmr1), .TMR3_I(tmr3),
    .TMR5_I(16'h0000), .TMR7_I(16'h0000), .TMR_RESET_O(tmr_rst), .PIN_I(pin_i),
    .ALT_PIN_I(alt_i), .PORT_WR_I(pwr), .PIN_DIR_OUT_I(dir), .PIN_O(pin_o),
    .PIN_DRIVE_O(drive_o), .ALT_PIN_O(alt_q), .ALT_DRIVE_O(alt_drv), .IRQ_REQ_O(irq),
    .IRQ_HIGH_O(irq_hi), .IRQ_LOW_O(irq_lo));
  // ----------------------------------------------------------------
  // bus and helper tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(n, e, q)
  endtask
  function automatic logic [7:0] cha(input int n, input logic [1:0] s);
    return OFS_CH_BASE + 8'(n * 16) + 8'({s, 2'b00});
  endfunction
  task automatic wait_hi(input int sel, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel == 0 ? irq[1] : tmr_rst[0]) !== 1'b1 && n < 300);
    if (n >= 300) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic pulse(input int i, input int k);
    repeat (k) begin
      pm.drive(i, 1'b0, 1'b1);
      pm.drive(i, 1'b0, 1'b0);
    end
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    be = 4'h1;
    addr = 8'h00;
    wdat = 32'h00000000;
    tmr_clr = 1'b0;
    tmr3 = 16'hA55A;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk("config", OFS_CONFIG, 32'h02);
    w8(8'hFC, 8'hFF);
    rchk("unmapped", 8'hFC, 32'h00);
    w8(OFS_TSEL_ONE, 8'h01);
    w8(OFS_ENABLES, 8'h03);
    w8(OFS_PRIOS, 8'h01);
    rchk("prios", OFS_PRIOS, 32'h01);
    pm.set_dir(0, 1'b0);
    w8(cha(0, SUB_CTRL), MODE_CAP_RISE);
    w8(OFS_FLAGS, 8'h00);
    pulse(0, 1);
    rchk("cap_lo", cha(0, SUB_LOW), 32'h5A);
    rchk("cap_hi", cha(0, SUB_HIGH), 32'hA5);
    `CHK("irq", 8'h01, irq)
    `CHK("irq_hi", 2'b10, {irq_hi, irq_lo})
    tmr3 <= 16'h1234;
    pulse(0, 1);
    rchk("overwrite", cha(0, SUB_LOW), 32'h34);
    rchk("flag_kept", OFS_FLAGS, 32'h01);
    w8(cha(0, SUB_CTRL), MODE_CAP_FALL);
    w8(OFS_FLAGS, 8'h00);
    pm.drive(0, 1'b0, 1'b1);
    rchk("no_rise", OFS_FLAGS, 32'h00);
    pm.drive(0, 1'b0, 1'b0);
    rchk("fall", OFS_FLAGS, 32'h01);
    $display("end capture");
    for (int m = 0; m < 2; m++) begin
      w8(cha(0, SUB_CTRL), MODE_OFF);
      w8(cha(0, SUB_CTRL), m == 0 ? MODE_CAP_4TH : MODE_CAP_16TH);
      w8(OFS_FLAGS, 8'h00);
      pulse(0, m == 0 ? 3 : 15);
      rchk("presc_early", OFS_FLAGS, 32'h00);
      pulse(0, 1);
      rchk("presc_hit", OFS_FLAGS, 32'h01);
    end
    w8(cha(0, SUB_CTRL), MODE_CAP_RISE);
    pm.set_dir(0, 1'b1);
    w8(OFS_FLAGS, 8'h00);
    pm.port_write(0);
    rchk("port_wr", OFS_FLAGS, 32'h01);
    w8(OFS_CONFIG, 8'h00);
    w8(cha(3, SUB_CTRL), MODE_CAP_RISE);
    w8(OFS_FLAGS, 8'h00);
    pulse(3, 1);
    rchk("primary_off", OFS_FLAGS, 32'h00);
    pm.drive(0, 1'b1, 1'b1);
    rchk("alt_group", OFS_FLAGS, 32'h08);
    w8(cha(3, SUB_CTRL), MODE_CMP_HIGH);
    repeat (2) @(posedge clk);
    `CHK("alt_drive", 9'h002, {alt_q, alt_drv, drive_o[3]})
    $display("end prescale and pins");
    w8(cha(1, SUB_LOW), 8'h40);
    w8(cha(1, SUB_HIGH), 8'h00);
    rchk("val_lo", cha(1, SUB_LOW), 32'h40);
    for (int i = 0; i < 4; i++) begin
      w8(cha(1, SUB_CTRL), MODE_OFF);
      repeat (2) @(posedge clk);
      `CHK("latch_off", 1'b0, pin_o[1])
      tmr_clr <= 1'b1;
      @(posedge clk);
      tmr_clr <= 1'b0;
      w8(cha(1, SUB_CTRL), cm[i]);
      w8(OFS_FLAGS, 8'h00);
      repeat (2) @(posedge clk);
      wait_hi(0, n);
      @(posedge clk);
      `CHK("cmp_pin", cx[i], {pin_o[1], drive_o[1]})
    end
    w8(cha(1, SUB_CTRL), MODE_CMP_SPEC);
    tmr_clr <= 1'b1;
    @(posedge clk);
    tmr_clr <= 1'b0;
    wait_hi(1, n);
    wait_hi(1, n);
    `CHK("period", 1'b1, (n >= 64 && n <= 72))
    $display("end compare");
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- inc/ccp_chan_if.sv ----
// Purpose: link between the register side and one channel unit
// Assumes: one instance per channel
// Notes  : unit drives status, host drives controls
`timescale 1ns/1ps
`default_nettype none
interface ccp_chan_if;
  logic [7:0]  wdata;
  logic        wr_ctrl;
  logic        wr_low;
  logic        wr_high;
  logic [15:0] timer;
  logic        pin_in;
  logic        port_wr;
  logic        dir_out;
  logic [3:0]  mode;
  logic [15:0] value;
  logic        event_hit;
  logic        special_trig;
  logic        out_latch;
  modport unit (input wdata, wr_ctrl, wr_low, wr_high, timer, pin_in, port_wr, dir_out,
                output mode, value, event_hit, special_trig, out_latch);
  modport host (output wdata, wr_ctrl, wr_low, wr_high, timer, pin_in, port_wr, dir_out,
                input mode, value, event_hit, special_trig, out_latch);
endinterface
`default_nettype wire

// ---- inc/ccp_pkg.sv ----
// Purpose: shared constants of the capture/compare unit
// Assumes: 8-bit registers in lane 0 of a 32-bit Avalon-MM slave
// Notes  : channels 3..10 sit at index 0..7
// Function
// - config bit at 1 routes channels 6..9 to primary pins, 0 to alternate
// - capture copies the whole 16-bit selected timer into the value bytes
// - mode field picks falling, rising, every 4th or every 16th rising edge
// - each capture sets the channel flag; only software clears it
// - a new capture overwrites an unread result, no overflow flag
// - port write on an output pin in capture mode is a capture condition
// - each channel uses the timer picked by its timer-select bits
// - prescaler clears when channel is off, not capturing, or reset
// - switching prescale settings directly keeps the prescaler count
// - compare mode detects equality of value and selected timer
// - a match drives high, low, toggles or leaves the pin, and sets flag
// - writing zero to channel control forces the compare latch low
// - mode 1010 leaves the pin alone and only raises the flag
// - mode 1011 emits a trigger that resets the assigned timer
// - channel four trigger starts no conversion
// - flags, enables and priorities share bit positions per channel
// - each value is two readable, writable bytes, low and high
package ccp_pkg;
  localparam int         NCH            = 8;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS      = 8'h00;
  localparam logic [7:0] OFS_ENABLES    = 8'h04;
  localparam logic [7:0] OFS_PRIOS      = 8'h08;
  localparam logic [7:0] OFS_TSEL_ONE   = 8'h0C;
  localparam logic [7:0] OFS_TSEL_TWO   = 8'h10;
  localparam logic [7:0] OFS_CONFIG     = 8'h14;
  localparam logic [7:0] OFS_CH_BASE    = 8'h20;
  localparam logic [7:0] OFS_CH_END     = 8'hA0;
  localparam logic [3:0] CH_BASE_IDX    = 4'h2;
  localparam logic [1:0] SUB_CTRL       = 2'h0;
  localparam logic [1:0] SUB_LOW        = 2'h1;
  localparam logic [1:0] SUB_HIGH       = 2'h2;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         PGS_BIT        = 1;
  localparam logic [7:0] RST_CONFIG     = 8'h02;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [3:0] PRESC_MASK_4   = 4'h3;
  localparam logic [3:0] PRESC_MASK_16  = 4'hF;
  // ----------------------------------------------------------------
  // mode field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_CMP_TOG   = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH   = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH  = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH  = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW   = 4'h9;
  localparam logic [3:0] MODE_CMP_SWINT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEC  = 4'hB;
endpackage
